// >>> src/sfwc_duty_sel.sv
// System fan output selection between curve result and error fallback.
// Assumes the curve duty and error flag are synchronous to the core clock.
`default_nettype none
module sfwc_duty_sel
    import sfwc_pkg::*;
(
    input  wire logic [1:0] error_mode,
    input  wire logic       thermal_error,
    input  wire logic [7:0] curve_duty,
    input  wire logic [7:0] preset_duty,
    output logic      [7:0] duty
);
    wire logic use_full   = error_mode[1] && thermal_error;
    wire logic use_preset = (error_mode == MODE_PRESET) && thermal_error;

    assign duty = use_full ? FULL_SPEED : (use_preset ? preset_duty : curve_duty);
endmodule
`default_nettype wire

// >>> src/sfwc_pkg.sv
// Constants shared by the system fan weighting register bank.
// Assumes one clock domain and an AHB-Lite master with word accesses.
`default_nettype none
package sfwc_pkg;
    localparam int NUM_REGS = 10;
    localparam int SRC_W    = 8;
    localparam int SRC_NUM  = 22;

    // Register indexes; byte address is four times the index
    localparam logic [7:0] IDX_POINT4_DUTY = 8'h67;
    localparam logic [7:0] IDX_WEIGHT_CFG  = 8'h68;
    localparam logic [7:0] IDX_TEMP_STEP   = 8'h69;
    localparam logic [7:0] IDX_STEP_TOL    = 8'h6a;
    localparam logic [7:0] IDX_DUTY_STEP   = 8'h6b;
    localparam logic [7:0] IDX_TEMP_BASE   = 8'h6c;
    localparam logic [7:0] IDX_DUTY_BASE   = 8'h6d;
    localparam logic [7:0] IDX_ERR_MODE    = 8'h6e;
    localparam logic [7:0] IDX_ERR_DUTY    = 8'h6f;
    localparam logic [7:0] IDX_CURVE_T1    = 8'h70;

    // Slots within the bank, in index order
    localparam logic [3:0] SLOT_POINT4 = 4'h0;
    localparam logic [3:0] SLOT_CFG    = 4'h1;
    localparam logic [3:0] SLOT_TSTEP  = 4'h2;
    localparam logic [3:0] SLOT_TOL    = 4'h3;
    localparam logic [3:0] SLOT_DSTEP  = 4'h4;
    localparam logic [3:0] SLOT_TBASE  = 4'h5;
    localparam logic [3:0] SLOT_DBASE  = 4'h6;
    localparam logic [3:0] SLOT_MODE   = 4'h7;
    localparam logic [3:0] SLOT_EDUTY  = 4'h8;
    localparam logic [3:0] SLOT_T1     = 4'h9;

    localparam logic [7:0] RESET_VALS [NUM_REGS] = '{
        8'he6, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'h28};
    // Reserved bits are not stored and read as zero
    localparam logic [7:0] WMASK [NUM_REGS] = '{
        8'hff, 8'h9f, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'h03, 8'hff, 8'hff};

    localparam int CFG_EN_BIT  = 7;
    localparam int CFG_SRC_MSB = 4;

    localparam logic [4:0] SRC_SYSTEM = 5'b0_0001;
    localparam logic [4:0] SRC_PROC   = 5'b0_0010;
    localparam logic [4:0] SRC_AUX    = 5'b0_0011;
    localparam logic [4:0] SRC_SMB0   = 5'b0_0100;
    localparam logic [4:0] SRC_AGENT0 = 5'b0_1100;
    localparam logic [4:0] SRC_CHIP0  = 5'b0_1110;
    localparam logic [4:0] SRC_BYTE   = 5'b1_0110;

    localparam logic [1:0] MODE_OFF    = 2'b00;
    localparam logic [1:0] MODE_PRESET = 2'b01;
    localparam logic [7:0] FULL_SPEED  = 8'hff;

    localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
endpackage
`default_nettype wire

// >>> src/sfwc_regs.sv
// System fan weighting register bank with AHB-Lite slave port.
// Assumes a single clock, word accesses only, and inputs synchronous to hclk.
`default_nettype none
module sfwc_regs
    import sfwc_pkg::*;
(
    input  wire logic                     hclk,
    input  wire logic                     hresetn,
    input  wire logic                     hsel,
    input  wire logic [31:0]              haddr,
    input  wire logic [1:0]               htrans,
    input  wire logic                     hwrite,
    input  wire logic [2:0]               hsize,
    input  wire logic [31:0]              hwdata,
    input  wire logic                     hready,
    output logic                          hreadyout,
    output logic                          hresp,
    output logic      [31:0]              hrdata,
    input  wire logic [SRC_NUM*SRC_W-1:0] source_temps,
    input  wire logic [7:0]               curve_duty,
    input  wire logic                     processor_thermal_error,
    output logic                          sys_fan_weight_enable,
    output logic      [4:0]               weight_temp_source_select,
    output logic      [7:0]               weight_temp_step,
    output logic      [7:0]               weight_temp_step_tolerance,
    output logic      [7:0]               weight_duty_step,
    output logic      [7:0]               weight_temp_base,
    output logic      [7:0]               weight_duty_base,
    output logic      [7:0]               curve_point4_duty,
    output logic      [7:0]               curve_temp_point1,
    output logic      [7:0]               weight_source_temp,
    output logic                          weight_source_valid,
    output logic      [7:0]               system_fan_output
);
    // Maps a byte address onto {hit, slot}
    function automatic logic [4:0] addr_decode(input logic [31:0] addr);
        logic [7:0] idx;
        logic       hit;
        idx = addr[9:2];
        hit = (addr[31:10] == '0) && (idx >= IDX_POINT4_DUTY) && (idx <= IDX_CURVE_T1);
        addr_decode = {hit, 4'(idx - IDX_POINT4_DUTY)};
    endfunction

    logic [7:0]  regs_r [NUM_REGS];
    logic        wr_pend_r;
    logic        wr_hit_r;
    logic [3:0]  wr_slot_r;
    logic [31:0] hrdata_r;
    logic [31:0] hrdata_nxt;
    logic [7:0]  src_temp_r;
    logic        src_valid_r;
    logic [7:0]  fan_out_r;

    wire logic       addr_phase = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == 2'b11);
    wire logic [4:0] a_dec      = addr_decode(haddr);
    wire logic       a_hit      = a_dec[4];
    wire logic [3:0] a_slot     = a_dec[3:0];
    wire logic       rd_take    = addr_phase && !hwrite;
    wire logic       wr_commit  = wr_pend_r && wr_hit_r;
    wire logic [7:0] wr_value   = hwdata[7:0] & WMASK[wr_slot_r];

    // A read right behind a write to the same slot sees the new value
    wire logic       fwd        = wr_commit && (wr_slot_r == a_slot);
    wire logic [7:0] rd_value   = fwd ? wr_value : regs_r[a_slot];

    assign hrdata_nxt = rd_take ? {24'h0000_00, a_hit ? rd_value : 8'h00} : hrdata_r;

    // Zero wait states and always OKAY; unmapped reads return zero
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = hrdata_r;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_r <= 1'b0;
            wr_hit_r  <= 1'b0;
            wr_slot_r <= 4'h0;
            hrdata_r  <= 32'h0000_0000;
        end else begin
            wr_pend_r <= addr_phase && hwrite;
            wr_hit_r  <= a_hit;
            wr_slot_r <= a_slot;
            hrdata_r  <= hrdata_nxt;
        end
    end

    // Register storage; reserved bits are masked off at write
    generate
        for (genvar i = 0; i < NUM_REGS; i++) begin : g_reg
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    regs_r[i] <= RESET_VALS[i];
                end else if (wr_commit && wr_slot_r == 4'(i)) begin
                    regs_r[i] <= wr_value;
                end
            end
        end
    endgenerate

    assign sys_fan_weight_enable      = regs_r[SLOT_CFG][CFG_EN_BIT];
    assign weight_temp_source_select  = regs_r[SLOT_CFG][CFG_SRC_MSB:0];
    assign weight_temp_step           = regs_r[SLOT_TSTEP];
    assign weight_temp_step_tolerance = regs_r[SLOT_TOL];
    assign weight_duty_step           = regs_r[SLOT_DSTEP];
    assign weight_temp_base           = regs_r[SLOT_TBASE];
    assign weight_duty_base           = regs_r[SLOT_DBASE];
    assign curve_point4_duty          = regs_r[SLOT_POINT4];
    assign curve_temp_point1          = regs_r[SLOT_T1];

    logic [7:0] sel_temp;
    logic       sel_valid;
    logic [7:0] duty_sel;

    sfwc_src_mux u_src_mux (
        .source_temps  (source_temps),
        .select_code   (weight_temp_source_select),
        .selected_temp (sel_temp),
        .select_valid  (sel_valid)
    );

    sfwc_duty_sel u_duty_sel (
        .error_mode    (regs_r[SLOT_MODE][1:0]),
        .thermal_error (processor_thermal_error),
        .curve_duty    (curve_duty),
        .preset_duty   (regs_r[SLOT_EDUTY]),
        .duty          (duty_sel)
    );

    // Registered so downstream arithmetic never sees a mid-write glitch
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            src_temp_r  <= 8'h00;
            src_valid_r <= 1'b0;
            fan_out_r   <= 8'h00;
        end else begin
            src_temp_r  <= sel_temp;
            src_valid_r <= sel_valid;
            fan_out_r   <= duty_sel;
        end
    end

    assign weight_source_temp  = src_temp_r;
    assign weight_source_valid = src_valid_r;
    assign system_fan_output   = fan_out_r;

    // Helper state for the checks below
    logic       rd_pend_r;
    logic [3:0] rd_slot_r;
    logic       rd_hit_r;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd_pend_r <= 1'b0;
            rd_slot_r <= 4'h0;
            rd_hit_r  <= 1'b0;
        end else begin
            rd_pend_r <= rd_take;
            rd_slot_r <= a_slot;
            rd_hit_r  <= a_hit;
        end
    end

    wire logic [4:0]             cur_code = weight_temp_source_select;
    wire logic [4:0]             cur_slot = cur_code - 5'h01;
    wire logic [SRC_W-1:0]       exp_temp = source_temps[cur_slot*SRC_W +: SRC_W];
    wire logic [1:0]             err_mode = regs_r[SLOT_MODE][1:0];

    AST_WEIGHT_EN_WRITE: assert property (@(posedge hclk) disable iff (!hresetn)
        wr_commit && wr_slot_r == SLOT_CFG |=> sys_fan_weight_enable == $past(hwdata[7]))
        else $error("weight enable did not follow config write");

    AST_SRC_SEL_WRITE: assert property (@(posedge hclk) disable iff (!hresetn)
        wr_commit && wr_slot_r == SLOT_CFG |=> weight_temp_source_select == $past(hwdata[4:0]))
        else $error("source select did not follow config write");

    AST_CFG_RESERVED: assert property (@(posedge hclk) disable iff (!hresetn)
        rd_pend_r && rd_hit_r && rd_slot_r == SLOT_CFG |-> hrdata[6:5] == 2'b00)
        else $error("reserved config bits read nonzero");

    // The sampled hresetn term skips the attempt on the edge that releases reset,
    // where the output flops are still held but the disable has already dropped
    AST_SRC_ROUTE: assert property (@(posedge hclk) disable iff (!hresetn)
        hresetn && cur_code >= SRC_SYSTEM && cur_code <= SRC_BYTE
        |=> weight_source_valid && weight_source_temp == $past(exp_temp))
        else $error("selected temperature not routed");

    AST_SRC_INVALID: assert property (@(posedge hclk) disable iff (!hresetn)
        hresetn && (cur_code == 5'h00 || cur_code > SRC_BYTE)
        |=> !weight_source_valid && weight_source_temp == 8'h00)
        else $error("invalid source code produced a temperature");

    AST_MODE_OFF: assert property (@(posedge hclk) disable iff (!hresetn)
        hresetn && err_mode == MODE_OFF |=> system_fan_output == $past(curve_duty))
        else $error("error mode off did not pass curve duty");

    AST_MODE_FULL: assert property (@(posedge hclk) disable iff (!hresetn)
        hresetn && err_mode[1] && processor_thermal_error |=> system_fan_output == FULL_SPEED)
        else $error("full speed mode did not force full duty");

    AST_MODE_PRESET: assert property (@(posedge hclk) disable iff (!hresetn)
        hresetn && err_mode == MODE_PRESET && processor_thermal_error
        |=> system_fan_output == $past(regs_r[SLOT_EDUTY]))
        else $error("preset mode did not output preset duty");

    AST_RESET_VALUES: assert property (@(posedge hclk)
        !hresetn |=> !hresetn || (regs_r[SLOT_EDUTY] == 8'hff && curve_point4_duty == 8'he6
        && curve_temp_point1 == 8'h28 && regs_r[SLOT_CFG] == 8'h01))
        else $error("reset value wrong after reset");

    AST_WRITE_READBACK: assert property (@(posedge hclk) disable iff (!hresetn)
        wr_commit |=> regs_r[$past(wr_slot_r)] == ($past(hwdata[7:0]) & WMASK[$past(wr_slot_r)]))
        else $error("written value not stored");

    AST_READ_DATA: assert property (@(posedge hclk) disable iff (!hresetn)
        rd_take && a_hit && !fwd |=> hrdata == {24'h0000_00, $past(regs_r[a_slot])})
        else $error("read data does not match register");

    AST_UNMAPPED_ZERO: assert property (@(posedge hclk) disable iff (!hresetn)
        rd_take && !a_hit |=> hrdata == 32'h0000_0000)
        else $error("unmapped read returned nonzero");

    // Each of the eight full-width registers follows a write to its own slot
    AST_PRESET_WRITE: assert property (@(posedge hclk) disable iff (!hresetn)
        wr_commit && wr_slot_r == SLOT_EDUTY |=> regs_r[SLOT_EDUTY] == $past(hwdata[7:0]))
        else $error("preset duty not written");

    AST_DUTY_BASE_WRITE: assert property (@(posedge hclk) disable iff (!hresetn)
        wr_commit && wr_slot_r == SLOT_DBASE |=> weight_duty_base == $past(hwdata[7:0]))
        else $error("duty base not written");

    AST_TEMP_BASE_WRITE: assert property (@(posedge hclk) disable iff (!hresetn)
        wr_commit && wr_slot_r == SLOT_TBASE |=> weight_temp_base == $past(hwdata[7:0]))
        else $error("temperature base not written");

    AST_TEMP_STEP_WRITE: assert property (@(posedge hclk) disable iff (!hresetn)
        wr_commit && wr_slot_r == SLOT_TSTEP |=> weight_temp_step == $past(hwdata[7:0]))
        else $error("temperature step not written");

    AST_DUTY_STEP_WRITE: assert property (@(posedge hclk) disable iff (!hresetn)
        wr_commit && wr_slot_r == SLOT_DSTEP |=> weight_duty_step == $past(hwdata[7:0]))
        else $error("weight step not written");

    AST_TOLERANCE_WRITE: assert property (@(posedge hclk) disable iff (!hresetn)
        wr_commit && wr_slot_r == SLOT_TOL |=> weight_temp_step_tolerance == $past(hwdata[7:0]))
        else $error("tolerance not written");

    AST_POINT4_WRITE: assert property (@(posedge hclk) disable iff (!hresetn)
        wr_commit && wr_slot_r == SLOT_POINT4 |=> curve_point4_duty == $past(hwdata[7:0]))
        else $error("point 4 duty not written");

    AST_CURVE_T1_WRITE: assert property (@(posedge hclk) disable iff (!hresetn)
        wr_commit && wr_slot_r == SLOT_T1 |=> curve_temp_point1 == $past(hwdata[7:0]))
        else $error("curve temperature 1 not written");

    AST_MODE_RESERVED: assert property (@(posedge hclk) disable iff (!hresetn)
        rd_pend_r && rd_hit_r && rd_slot_r == SLOT_MODE |-> hrdata[7:2] == 6'h00)
        else $error("reserved mode bits read nonzero");

    AST_RESET_ZERO: assert property (@(posedge hclk)
        !hresetn |=> !hresetn || (weight_temp_step == 8'h00 && weight_duty_step == 8'h00
        && weight_temp_base == 8'h00 && weight_duty_base == 8'h00 && !sys_fan_weight_enable))
        else $error("zero reset value wrong after reset");

    AST_REGS_HOLD: assert property (@(posedge hclk) disable iff (!hresetn)
        hresetn && !wr_commit |=> $stable(weight_temp_step_tolerance) && $stable(curve_point4_duty)
        && $stable(curve_temp_point1) && $stable(weight_duty_base))
        else $error("register changed without a write");

    // Fixed byte lanes per code, independent of the mux arithmetic
    AST_LANE_SYSTEM: assert property (@(posedge hclk) disable iff (!hresetn)
        hresetn && cur_code == SRC_SYSTEM |=> weight_source_temp == $past(source_temps[7:0]))
        else $error("system input lane wrong");

    AST_LANE_PROC: assert property (@(posedge hclk) disable iff (!hresetn)
        hresetn && cur_code == SRC_PROC |=> weight_source_temp == $past(source_temps[15:8]))
        else $error("processor input lane wrong");

    AST_LANE_AUX: assert property (@(posedge hclk) disable iff (!hresetn)
        hresetn && cur_code == SRC_AUX |=> weight_source_temp == $past(source_temps[23:16]))
        else $error("auxiliary input lane wrong");

    AST_LANE_SMB0: assert property (@(posedge hclk) disable iff (!hresetn)
        hresetn && cur_code == SRC_SMB0 |=> weight_source_temp == $past(source_temps[31:24]))
        else $error("first bus reading lane wrong");

    AST_LANE_SMB7: assert property (@(posedge hclk) disable iff (!hresetn)
        hresetn && cur_code == 5'h0b |=> weight_source_temp == $past(source_temps[87:80]))
        else $error("last bus reading lane wrong");

    AST_LANE_AGENT0: assert property (@(posedge hclk) disable iff (!hresetn)
        hresetn && cur_code == SRC_AGENT0 |=> weight_source_temp == $past(source_temps[95:88]))
        else $error("agent 0 lane wrong");

    AST_LANE_AGENT1: assert property (@(posedge hclk) disable iff (!hresetn)
        hresetn && cur_code == 5'h0d |=> weight_source_temp == $past(source_temps[103:96]))
        else $error("agent 1 lane wrong");

    AST_LANE_CHIP0: assert property (@(posedge hclk) disable iff (!hresetn)
        hresetn && cur_code == SRC_CHIP0 |=> weight_source_temp == $past(source_temps[111:104]))
        else $error("first chipset lane wrong");

    AST_LANE_CHIP7: assert property (@(posedge hclk) disable iff (!hresetn)
        hresetn && cur_code == 5'h15 |=> weight_source_temp == $past(source_temps[167:160]))
        else $error("last chipset lane wrong");

    AST_LANE_BYTE: assert property (@(posedge hclk) disable iff (!hresetn)
        hresetn && cur_code == SRC_BYTE |=> weight_source_temp == $past(source_temps[175:168]))
        else $error("byte value lane wrong");

    COV_CFG_WRITE: cover property (@(posedge hclk) disable iff (!hresetn)
        wr_commit && wr_slot_r == SLOT_CFG);

    COV_PRESET_OUT: cover property (@(posedge hclk) disable iff (!hresetn)
        err_mode == MODE_PRESET && processor_thermal_error ##1 system_fan_output != curve_duty);

    COV_FULL_OUT: cover property (@(posedge hclk) disable iff (!hresetn)
        err_mode == 2'b11 && processor_thermal_error);

    COV_WRITE_THEN_READ: cover property (@(posedge hclk) disable iff (!hresetn)
        fwd && rd_take);

    COV_SOURCE_INVALID: cover property (@(posedge hclk) disable iff (!hresetn)
        cur_code > SRC_BYTE);

    // hsize is accepted but only whole-word transfers are expected
    wire logic unused_ok = ^{hsize, haddr[1:0]};
endmodule
`default_nettype wire

// >>> src/sfwc_src_mux.sv
// Weighting temperature source selector.
// Assumes source_temps packs code 1 in the low byte up to code 22.
`default_nettype none
module sfwc_src_mux
    import sfwc_pkg::*;
(
    input  wire logic [SRC_NUM*SRC_W-1:0] source_temps,
    input  wire logic [4:0]               select_code,
    output logic      [SRC_W-1:0]         selected_temp,
    output logic                          select_valid
);
    wire logic [4:0] slot = select_code - 5'h01;

    // Code 0 and codes above the byte-wide source select nothing
    assign select_valid  = (select_code >= SRC_SYSTEM) && (select_code <= SRC_BYTE);
    assign selected_temp = select_valid ? source_temps[slot*SRC_W +: SRC_W] : '0;
endmodule
`default_nettype wire

// >>> testbench/system_fan_weight_control_regs_test.sv
// Self-checking bench for the system fan weighting register bank.
// Assumes sfwc_regs is a zero-wait AHB-Lite slave with byte address 4 x index.
`default_nettype none
module system_fan_weight_control_regs_test
    import sfwc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic                     hclk;
    logic                     hresetn;
    logic                     hsel;
    logic [31:0]              haddr;
    logic [1:0]               htrans;
    logic                     hwrite;
    logic [2:0]               hsize;
    logic [31:0]              hwdata;
    wire logic                hready;
    logic                     hreadyout;
    logic                     hresp;
    logic [31:0]              hrdata;
    logic [SRC_NUM*SRC_W-1:0] source_temps;
    logic [7:0]               curve_duty;
    logic                     processor_thermal_error;
    logic                     sys_fan_weight_enable;
    logic [4:0]               weight_temp_source_select;
    logic [7:0]               weight_temp_step;
    logic [7:0]               weight_temp_step_tolerance;
    logic [7:0]               weight_duty_step;
    logic [7:0]               weight_temp_base;
    logic [7:0]               weight_duty_base;
    logic [7:0]               curve_point4_duty;
    logic [7:0]               curve_temp_point1;
    logic [7:0]               weight_source_temp;
    logic                     weight_source_valid;
    logic [7:0]               system_fan_output;
    int                       err_total;
    int                       checks;
    logic [31:0]              rd_val;
    logic [7:0]               exp_b;
    logic [7:0]               rst_tab [10] = '{8'he6, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'h28};
    logic [7:0]               msk_tab [10] = '{8'hff, 8'h9f, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'h03, 8'hff, 8'hff};
    logic [7:0]               pats [3]     = '{8'hff, 8'ha5, 8'h5a};

    // Single slave, so its ready is the bus ready
    assign hready = hreadyout;

    sfwc_regs dut_u (
        .hclk                      (hclk),
        .hresetn                   (hresetn),
        .hsel                      (hsel),
        .haddr                     (haddr),
        .htrans                    (htrans),
        .hwrite                    (hwrite),
        .hsize                     (hsize),
        .hwdata                    (hwdata),
        .hready                    (hready),
        .hreadyout                 (hreadyout),
        .hresp                     (hresp),
        .hrdata                    (hrdata),
        .source_temps              (source_temps),
        .curve_duty                (curve_duty),
        .processor_thermal_error   (processor_thermal_error),
        .sys_fan_weight_enable     (sys_fan_weight_enable),
        .weight_temp_source_select (weight_temp_source_select),
        .weight_temp_step          (weight_temp_step),
        .weight_temp_step_tolerance(weight_temp_step_tolerance),
        .weight_duty_step          (weight_duty_step),
        .weight_temp_base          (weight_temp_base),
        .weight_duty_base          (weight_duty_base),
        .curve_point4_duty         (curve_point4_duty),
        .curve_temp_point1         (curve_temp_point1),
        .weight_source_temp        (weight_source_temp),
        .weight_source_valid       (weight_source_valid),
        .system_fan_output         (system_fan_output)
    );

    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Called right after a rising edge; returns at the edge that ends the data phase
    task automatic xfer(input logic [7:0] idx, input logic wr, input logic [7:0] wdat, output logic [31:0] rdat);
        hsel   <= 1'b1;
        haddr  <= {22'h00_0000, idx, 2'b00};
        htrans <= HTRANS_NONSEQ;
        hwrite <= wr;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= {24'h00_0000, wdat};
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        rdat = hrdata;
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic [31:0] dummy;
        xfer(idx, 1'b1, d, dummy);
    endtask

    task automatic rd_chk(input string name, input logic [7:0] idx, input logic [7:0] exp);
        logic [31:0] r;
        xfer(idx, 1'b0, 8'h00, r);
        chk(name, r, {24'h00_0000, exp});
        chk("response", {31'h0000_0000, hresp}, 32'h0000_0000);
        chk("ready", {31'h0000_0000, hreadyout}, 32'h0000_0001);
    endtask

    task automatic end_test(input string name);
        $display("test %s done, mismatches so far %0d", name, err_total);
    endtask

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    initial begin
        #200_000;
        err_total++;
        summarize();
    end

    initial begin
        err_total = 0;
        checks = 0;
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0000_0000;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        hwdata = 32'h0000_0000;
        curve_duty = 8'h40;
        processor_thermal_error = 1'b0;
        for (int k = 0; k < SRC_NUM; k++) source_temps[8*k +: 8] = 8'(8'h30 + k);
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        chk("enable port", {31'h0, sys_fan_weight_enable}, 32'h0000_0000);
        chk("source port", {27'h0, weight_temp_source_select}, 32'h0000_0001);
        chk("point4 port", {24'h0, curve_point4_duty}, 32'h0000_00e6);
        chk("temp1 port", {24'h0, curve_temp_point1}, 32'h0000_0028);
        for (int i = 0; i < 10; i++) rd_chk("reset value", 8'(8'h67 + i), rst_tab[i]);
        end_test("reset");
        foreach (pats[p]) begin
            for (int i = 0; i < 10; i++) wr(8'(8'h67 + i), pats[p]);
            for (int i = 0; i < 10; i++) rd_chk("readback", 8'(8'h67 + i), pats[p] & msk_tab[i]);
        end
        @(posedge hclk);
        chk("temp step port", {24'h0, weight_temp_step}, 32'h0000_005a);
        chk("tolerance port", {24'h0, weight_temp_step_tolerance}, 32'h0000_005a);
        chk("duty step port", {24'h0, weight_duty_step}, 32'h0000_005a);
        chk("temp base port", {24'h0, weight_temp_base}, 32'h0000_005a);
        chk("duty base port", {24'h0, weight_duty_base}, 32'h0000_005a);
        chk("point4 port", {24'h0, curve_point4_duty}, 32'h0000_005a);
        chk("temp1 port", {24'h0, curve_temp_point1}, 32'h0000_005a);
        wr(8'h6d, 8'h3c);
        rd_chk("write then read", 8'h6d, 8'h3c);
        end_test("read write");
        rd_chk("unmapped below", 8'h66, 8'h00);
        rd_chk("unmapped above", 8'h71, 8'h00);
        wr(8'h66, 8'h77);
        rd_chk("neighbour kept", 8'h67, 8'h5a);
        end_test("unmapped");
        // Reserved bits 6:5 are set on purpose and must not leak into the select
        for (int c = 0; c < 24; c++) begin
            wr(8'h68, {c[0], 2'b11, c[4:0]});
            repeat (3) @(posedge hclk);
            exp_b = (c >= 1 && c <= 22) ? 8'(8'h30 + c - 1) : 8'h00;
            chk("enable port", {31'h0, sys_fan_weight_enable}, 32'(c % 2));
            chk("source port", {27'h0, weight_temp_source_select}, 32'(c));
            chk("source valid", {31'h0, weight_source_valid}, 32'(c >= 1 && c <= 22));
            chk("source temp", {24'h0, weight_source_temp}, {24'h0, exp_b});
        end
        end_test("source select");
        wr(8'h6f, 8'h33);
        for (int m = 0; m < 4; m++) begin
            for (int e = 0; e < 2; e++) begin
                wr(8'h6e, 8'(m));
                processor_thermal_error <= e[0];
                curve_duty <= 8'(8'h40 + 2 * m + e);
                repeat (3) @(posedge hclk);
                exp_b = 8'(8'h40 + 2 * m + e);
                if (e == 1 && m == 1) exp_b = 8'h33;
                if (e == 1 && m >= 2) exp_b = 8'hff;
                chk("fan output", {24'h0, system_fan_output}, {24'h0, exp_b});
            end
        end
        end_test("error fallback");
        // Asynchronous reset in mid-run must restore written registers
        hresetn <= 1'b0;
        @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rd_chk("preset after reset", 8'h6f, 8'hff);
        rd_chk("tolerance after reset", 8'h6a, 8'h00);
        chk("fan output", {24'h0, system_fan_output}, 32'h0000_0047);
        end_test("second reset");
        summarize();
    end
endmodule
`default_nettype wire
